/* envsq_defs.vh */
// constants shared by the mode sequencer core and its helpers
// assumes a 100 MHz core clock and a 32-bit register bus
`ifndef ENVSQ_DEFS_VH
`define ENVSQ_DEFS_VH

// ****************************************
// timing
// ****************************************
`define ENVSQ_CLK_MHZ 100
`define ENVSQ_STANDBY_UNIT_US 500

// ****************************************
// register byte offsets
// ****************************************
`define ENVSQ_ADDR_CTRL_MEAS 8'h00
`define ENVSQ_ADDR_CONFIG 8'h04
`define ENVSQ_ADDR_CTRL_HUM 8'h08
`define ENVSQ_ADDR_SOFT_RESET 8'h0c
`define ENVSQ_ADDR_STATUS 8'h10
`define ENVSQ_ADDR_TEMP_DATA 8'h14
`define ENVSQ_ADDR_PRESS_DATA 8'h18
`define ENVSQ_ADDR_HUM_DATA 8'h1c

// ****************************************
// field positions
// ****************************************
`define ENVSQ_MODE_MSB 1
`define ENVSQ_MODE_LSB 0
`define ENVSQ_TOS_MSB 4
`define ENVSQ_TOS_LSB 2
`define ENVSQ_POS_MSB 7
`define ENVSQ_POS_LSB 5
`define ENVSQ_SB_MSB 2
`define ENVSQ_SB_LSB 0
`define ENVSQ_FILT_MSB 6
`define ENVSQ_FILT_LSB 4
`define ENVSQ_HOS_MSB 2
`define ENVSQ_HOS_LSB 0

// ****************************************
// encodings and reset values
// ****************************************
`define ENVSQ_MODE_IDLE 2'h0
`define ENVSQ_MODE_ONESHOT 2'h1
`define ENVSQ_MODE_ONESHOT_ALT 2'h2
`define ENVSQ_MODE_PERIODIC 2'h3
`define ENVSQ_RST_OS 3'h0
`define ENVSQ_RST_SEL 3'h0
`define ENVSQ_SOFT_RESET_KEY 8'h5a
`define ENVSQ_SKIP_MARK 20'h80000
`define ENVSQ_CH_TEMP 2'h0
`define ENVSQ_CH_PRESS 2'h1
`define ENVSQ_CH_HUM 2'h2
`define ENVSQ_RESP_OKAY 2'h0
`define ENVSQ_RESP_SLVERR 2'h2

// ****************************************
// standby lengths in half-millisecond ticks
// ****************************************
`define ENVSQ_SB_TICKS_0 11'h001
`define ENVSQ_SB_TICKS_1 11'h07d
`define ENVSQ_SB_TICKS_2 11'h0fa
`define ENVSQ_SB_TICKS_3 11'h1f4
`define ENVSQ_SB_TICKS_4 11'h3e8
`define ENVSQ_SB_TICKS_5 11'h7d0
`define ENVSQ_SB_TICKS_6 11'h014
`define ENVSQ_SB_TICKS_7 11'h028

`endif

/* envsq_iir.v */
// one smoothing filter channel with its memory and output register
// assumes load and clear are one-cycle pulses on the core clock; init may be held high for several cycles
`timescale 1ns/1ps
`include "envsq_defs.vh"

module envsq_iir #(
  parameter W = 20
) (
  input wire clock,
  input wire sys_rst,
  input wire init,
  input wire clear,
  input wire load,
  input wire skip,
  input wire [2:0] coef_sel,
  input wire [W-1:0] sample,
  output reg [W-1:0] result
);

  // ****************************************
  // coefficient as a shift
  // ****************************************
  function [2:0] coef_shift;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: coef_shift = 3'h0;
        3'h1: coef_shift = 3'h1;
        3'h2: coef_shift = 3'h2;
        3'h3: coef_shift = 3'h3;
        default: coef_shift = 3'h4;
      endcase
    end
  endfunction

  reg [W-1:0] mem;
  reg primed;
  wire [2:0] k = coef_shift(coef_sel);
  wire [W+4:0] acc = ({5'h0, mem} << k) - {5'h0, mem} + {5'h0, sample};
  wire [W+4:0] quot = acc >> k;
  wire [W-1:0] filt = quot[W-1:0];
  // a restart landing with a load lets this load pass through unfiltered
  wire [W-1:0] fresh = (!primed || clear || k == 3'h0) ? sample : filt;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mem <= {W{1'b0}};
      primed <= 1'b0;
      result <= {W{1'b0}};
    end else if (init) begin
      mem <= {W{1'b0}};
      primed <= 1'b0;
      result <= {W{1'b0}};
    end else begin
      if (clear) begin
        primed <= 1'b0;
      end
      if (load) begin
        if (skip) begin
          result <= `ENVSQ_SKIP_MARK;
        end else begin
          mem <= fresh;
          result <= fresh;
          primed <= 1'b1;
        end
      end
    end
  end

endmodule

/* envsq_standby.v */
// standby timer for periodic mode, counted in half-millisecond ticks
// assumes start is a one-cycle pulse; halt stops a running wait
`timescale 1ns/1ps
`include "envsq_defs.vh"

module envsq_standby #(
  parameter HALF_MS_CYCLES = `ENVSQ_STANDBY_UNIT_US * `ENVSQ_CLK_MHZ
) (
  input wire clock,
  input wire sys_rst,
  input wire halt,
  input wire start,
  input wire [2:0] sel,
  output reg done
);

  localparam DW = $clog2(HALF_MS_CYCLES + 1);
  localparam [31:0] DIV_LAST_W = HALF_MS_CYCLES - 1;
  localparam [DW-1:0] DIV_LAST = DIV_LAST_W[DW-1:0];

  function [10:0] sb_ticks;
    input [2:0] s;
    begin
      case (s)
        3'h0: sb_ticks = `ENVSQ_SB_TICKS_0;
        3'h1: sb_ticks = `ENVSQ_SB_TICKS_1;
        3'h2: sb_ticks = `ENVSQ_SB_TICKS_2;
        3'h3: sb_ticks = `ENVSQ_SB_TICKS_3;
        3'h4: sb_ticks = `ENVSQ_SB_TICKS_4;
        3'h5: sb_ticks = `ENVSQ_SB_TICKS_5;
        3'h6: sb_ticks = `ENVSQ_SB_TICKS_6;
        default: sb_ticks = `ENVSQ_SB_TICKS_7;
      endcase
    end
  endfunction

  reg running;
  reg [DW-1:0] div;
  reg [10:0] left;
  wire tick = running && (div == DIV_LAST);

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      running <= 1'b0;
      div <= {DW{1'b0}};
      left <= 11'h000;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (halt) begin
        running <= 1'b0;
      end else if (start) begin
        running <= 1'b1;
        div <= {DW{1'b0}};
        left <= sb_ticks(sel);
      end else if (tick) begin
        div <= {DW{1'b0}};
        if (left == 11'h001) begin
          running <= 1'b0;
          done <= 1'b1;
        end else begin
          left <= left - 11'h001;
        end
      end else if (running) begin
        div <= div + {{(DW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

/* envsq_core.v */
// mode sequencer core: supply reset, operating modes, measurement period
// assumes an AXI4-Lite master on the same clock and a conversion front end
// on the same clock that answers each conv_start with one conv_done pulse
`timescale 1ns/1ps
`include "envsq_defs.vh"

module envsq_core #(
  parameter HALF_MS_CYCLES = `ENVSQ_STANDBY_UNIT_US * `ENVSQ_CLK_MHZ
) (
  input wire clock,
  input wire sys_rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire core_supply_ok,
  input wire interface_supply_ok,
  output reg iface_enable,
  output reg analog_enable,
  output reg conv_start,
  output reg [1:0] conv_channel,
  output reg [2:0] conv_oversample,
  input wire conv_done,
  input wire [19:0] conv_result
);

  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_T_REQ = 4'h1;
  localparam [3:0] S_T_WAIT = 4'h2;
  localparam [3:0] S_P_REQ = 4'h3;
  localparam [3:0] S_P_WAIT = 4'h4;
  localparam [3:0] S_H_REQ = 4'h5;
  localparam [3:0] S_H_WAIT = 4'h6;
  localparam [3:0] S_FILT = 4'h7;
  localparam [3:0] S_END = 4'h8;
  localparam [3:0] S_STANDBY = 4'h9;

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `ENVSQ_ADDR_CTRL_MEAS) || (a == `ENVSQ_ADDR_CONFIG) ||
                  (a == `ENVSQ_ADDR_CTRL_HUM) || (a == `ENVSQ_ADDR_SOFT_RESET) ||
                  (a == `ENVSQ_ADDR_STATUS) || (a == `ENVSQ_ADDR_TEMP_DATA) ||
                  (a == `ENVSQ_ADDR_PRESS_DATA) || (a == `ENVSQ_ADDR_HUM_DATA);
    end
  endfunction

  function is_active_mode;
    input [1:0] m;
    begin
      is_active_mode = (m != `ENVSQ_MODE_IDLE);
    end
  endfunction

  // ****************************************
  // supply monitoring and internal reset
  // ****************************************
  reg core_s1;
  reg core_s2;
  reg io_s1;
  reg io_s2;
  reg por_done;
  reg soft_rst_req;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      core_s1 <= 1'b0;
      core_s2 <= 1'b0;
      io_s1 <= 1'b0;
      io_s2 <= 1'b0;
      por_done <= 1'b0;
      iface_enable <= 1'b0;
    end else begin
      core_s1 <= core_supply_ok;
      core_s2 <= core_s1;
      io_s1 <= interface_supply_ok;
      io_s2 <= io_s1;
      iface_enable <= core_s2;
      if (!core_s2) begin
        por_done <= 1'b0;
      end else if (io_s2) begin
        por_done <= 1'b1;
      end
    end
  end

  wire logic_clear = !por_done || soft_rst_req;

  // ****************************************
  // register bus slave
  // ****************************************
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire low_byte = w_strb_q[0];

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ENVSQ_RESP_OKAY;
      soft_rst_req <= 1'b0;
    end else begin
      soft_rst_req <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_addr_q) ? `ENVSQ_RESP_OKAY : `ENVSQ_RESP_SLVERR;
        if (aw_addr_q == `ENVSQ_ADDR_SOFT_RESET && low_byte &&
            w_data_q[7:0] == `ENVSQ_SOFT_RESET_KEY) begin
          soft_rst_req <= 1'b1;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ****************************************
  // settings and mode requests
  // ****************************************
  reg [3:0] state;
  reg [1:0] active_mode;
  reg [1:0] pending_mode;
  reg mode_pending;
  reg [2:0] temp_os;
  reg [2:0] press_os;
  reg [2:0] hum_os;
  reg [2:0] standby_time_sel;
  reg [2:0] filter_sel;
  reg filter_clear;
  reg filt_load;
  reg sb_start;
  reg t_skip;
  reg p_skip;
  reg [19:0] raw_t;
  reg [19:0] raw_p;
  reg [15:0] hum_data;
  wire [19:0] temp_data;
  wire [19:0] press_data;
  wire sb_done;

  wire measuring = (state != S_IDLE) && (state != S_STANDBY);
  wire wr_meas = do_write && low_byte && (aw_addr_q == `ENVSQ_ADDR_CTRL_MEAS);
  wire [1:0] wr_mode = w_data_q[`ENVSQ_MODE_MSB:`ENVSQ_MODE_LSB];
  wire mode_now = wr_meas && !mode_pending && !measuring;
  wire mode_defer = wr_meas && !mode_pending && measuring;
  wire cmd_valid = mode_now || mode_pending;
  wire [1:0] cmd_mode = mode_now ? wr_mode : pending_mode;
  wire [1:0] end_mode = mode_pending ? pending_mode : active_mode;

  // ****************************************
  // measurement sequencer
  // ****************************************
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= S_IDLE;
      active_mode <= `ENVSQ_MODE_IDLE;
      pending_mode <= `ENVSQ_MODE_IDLE;
      mode_pending <= 1'b0;
      temp_os <= `ENVSQ_RST_OS;
      press_os <= `ENVSQ_RST_OS;
      hum_os <= `ENVSQ_RST_OS;
      standby_time_sel <= `ENVSQ_RST_SEL;
      filter_sel <= `ENVSQ_RST_SEL;
      filter_clear <= 1'b0;
      filt_load <= 1'b0;
      sb_start <= 1'b0;
      t_skip <= 1'b0;
      p_skip <= 1'b0;
      raw_t <= 20'h00000;
      raw_p <= 20'h00000;
      hum_data <= 16'h0000;
      conv_start <= 1'b0;
      conv_channel <= `ENVSQ_CH_TEMP;
      conv_oversample <= 3'h0;
      analog_enable <= 1'b0;
    end else if (logic_clear) begin
      state <= S_IDLE;
      active_mode <= `ENVSQ_MODE_IDLE;
      pending_mode <= `ENVSQ_MODE_IDLE;
      mode_pending <= 1'b0;
      temp_os <= `ENVSQ_RST_OS;
      press_os <= `ENVSQ_RST_OS;
      hum_os <= `ENVSQ_RST_OS;
      standby_time_sel <= `ENVSQ_RST_SEL;
      filter_sel <= `ENVSQ_RST_SEL;
      filter_clear <= 1'b0;
      filt_load <= 1'b0;
      sb_start <= 1'b0;
      t_skip <= 1'b0;
      p_skip <= 1'b0;
      raw_t <= 20'h00000;
      raw_p <= 20'h00000;
      hum_data <= 16'h0000;
      conv_start <= 1'b0;
      conv_channel <= `ENVSQ_CH_TEMP;
      conv_oversample <= 3'h0;
      analog_enable <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      filt_load <= 1'b0;
      sb_start <= 1'b0;
      filter_clear <= 1'b0;
      analog_enable <= measuring;
      case (state)
        S_IDLE: begin
          if (cmd_valid) begin
            active_mode <= cmd_mode;
            mode_pending <= 1'b0;
            if (is_active_mode(cmd_mode)) begin
              state <= S_T_REQ;
            end
          end
        end
        S_STANDBY: begin
          if (cmd_valid && cmd_mode != `ENVSQ_MODE_PERIODIC) begin
            active_mode <= cmd_mode;
            mode_pending <= 1'b0;
            state <= is_active_mode(cmd_mode) ? S_T_REQ : S_IDLE;
          end else if (cmd_valid) begin
            mode_pending <= 1'b0;
          end else if (sb_done) begin
            state <= S_T_REQ;
          end
        end
        S_T_REQ: begin
          t_skip <= (temp_os == 3'h0);
          if (temp_os == 3'h0) begin
            state <= S_P_REQ;
          end else begin
            conv_start <= 1'b1;
            conv_channel <= `ENVSQ_CH_TEMP;
            conv_oversample <= temp_os;
            state <= S_T_WAIT;
          end
        end
        S_T_WAIT: begin
          if (conv_done) begin
            raw_t <= conv_result;
            state <= S_P_REQ;
          end
        end
        S_P_REQ: begin
          p_skip <= (press_os == 3'h0);
          if (press_os == 3'h0) begin
            state <= S_H_REQ;
          end else begin
            conv_start <= 1'b1;
            conv_channel <= `ENVSQ_CH_PRESS;
            conv_oversample <= press_os;
            state <= S_P_WAIT;
          end
        end
        S_P_WAIT: begin
          if (conv_done) begin
            raw_p <= conv_result;
            state <= S_H_REQ;
          end
        end
        S_H_REQ: begin
          if (hum_os == 3'h0) begin
            state <= S_FILT;
          end else begin
            conv_start <= 1'b1;
            conv_channel <= `ENVSQ_CH_HUM;
            conv_oversample <= hum_os;
            state <= S_H_WAIT;
          end
        end
        S_H_WAIT: begin
          if (conv_done) begin
            hum_data <= conv_result[15:0];
            state <= S_FILT;
          end
        end
        S_FILT: begin
          filt_load <= 1'b1;
          state <= S_END;
        end
        S_END: begin
          mode_pending <= 1'b0;
          active_mode <= end_mode;
          if (end_mode == `ENVSQ_MODE_PERIODIC) begin
            sb_start <= 1'b1;
            state <= S_STANDBY;
          end else if (is_active_mode(end_mode) && mode_pending) begin
            state <= S_T_REQ;
          end else begin
            active_mode <= `ENVSQ_MODE_IDLE;
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
      if (wr_meas) begin
        temp_os <= w_data_q[`ENVSQ_TOS_MSB:`ENVSQ_TOS_LSB];
        press_os <= w_data_q[`ENVSQ_POS_MSB:`ENVSQ_POS_LSB];
      end
      if (mode_defer) begin
        pending_mode <= wr_mode;
        mode_pending <= 1'b1;
      end
      if (do_write && low_byte && aw_addr_q == `ENVSQ_ADDR_CTRL_HUM && !mode_pending) begin
        hum_os <= w_data_q[`ENVSQ_HOS_MSB:`ENVSQ_HOS_LSB];
      end
      if (do_write && low_byte && aw_addr_q == `ENVSQ_ADDR_CONFIG) begin
        standby_time_sel <= w_data_q[`ENVSQ_SB_MSB:`ENVSQ_SB_LSB];
        filter_sel <= w_data_q[`ENVSQ_FILT_MSB:`ENVSQ_FILT_LSB];
        filter_clear <= 1'b1;
      end
    end
  end

  // ****************************************
  // filters and standby timer
  // ****************************************
  envsq_iir #(
    .W(20)
  ) u_temp_filt (
    .clock(clock),
    .sys_rst(sys_rst),
    .init(logic_clear),
    .clear(filter_clear),
    .load(filt_load),
    .skip(t_skip),
    .coef_sel(filter_sel),
    .sample(raw_t),
    .result(temp_data)
  );

  envsq_iir #(
    .W(20)
  ) u_press_filt (
    .clock(clock),
    .sys_rst(sys_rst),
    .init(logic_clear),
    .clear(filter_clear),
    .load(filt_load),
    .skip(p_skip),
    .coef_sel(filter_sel),
    .sample(raw_p),
    .result(press_data)
  );

  envsq_standby #(
    .HALF_MS_CYCLES(HALF_MS_CYCLES)
  ) u_standby (
    .clock(clock),
    .sys_rst(sys_rst),
    .halt(logic_clear || state != S_STANDBY),
    .start(sb_start),
    .sel(standby_time_sel),
    .done(sb_done)
  );

  // ****************************************
  // read path
  // ****************************************
  reg [31:0] rd_value;

  always @* begin
    rd_value = 32'h00000000;
    case (s_axi_araddr)
      `ENVSQ_ADDR_CTRL_MEAS: rd_value = {24'h000000, press_os, temp_os, active_mode};
      `ENVSQ_ADDR_CONFIG: rd_value = {25'h0000000, filter_sel, 1'b0, standby_time_sel};
      `ENVSQ_ADDR_CTRL_HUM: rd_value = {29'h00000000, hum_os};
      `ENVSQ_ADDR_STATUS: rd_value = {28'h0000000, active_mode, mode_pending, measuring};
      `ENVSQ_ADDR_TEMP_DATA: rd_value = {12'h000, temp_data};
      `ENVSQ_ADDR_PRESS_DATA: rd_value = {12'h000, press_data};
      `ENVSQ_ADDR_HUM_DATA: rd_value = {16'h0000, hum_data};
      default: rd_value = 32'h00000000;
    endcase
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ENVSQ_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_value;
        s_axi_rresp <= is_mapped(s_axi_araddr) ? `ENVSQ_RESP_OKAY : `ENVSQ_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

/* envsq_fe_model.sv */
// conversion front end model: one done pulse per start request
// assumes the core clock; slow stretches the answer to seven cycles
`timescale 1ns/1ps
module envsq_fe_model (
  input wire clock,
  input wire slow,
  input wire conv_start,
  input wire [1:0] conv_channel,
  input wire [19:0] base,
  output reg conv_done = 0,
  output reg [19:0] conv_result = 0,
  output reg [5:0] order_log = 0
);
  reg [2:0] cnt = 0;
  // result toggles outside the done cycle so stale data never looks valid
  always @(posedge clock) begin
    conv_done <= 1'b0;
    conv_result <= ~conv_result;
    if (conv_start) begin
      cnt <= slow ? 3'h7 : 3'h1;
      order_log <= {order_log[3:0], conv_channel};
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
      if (cnt == 3'h1) begin
        conv_done <= 1'b1;
        conv_result <= base + {18'h0, conv_channel};
      end
    end
  end
endmodule

/* envsq_core_props.sv */
// assertions on the mode sequencer core ports
// assumes it is bound into envsq_core; one clock domain
`timescale 1ns/1ps
module envsq_core_props (
  input wire clock,
  input wire sys_rst,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire core_supply_ok,
  input wire iface_enable,
  input wire analog_enable,
  input wire conv_start,
  input wire [1:0] conv_channel,
  input wire [2:0] conv_oversample
);
  // ****
  // bus, supply and conversion checks
  // ****
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_core_lost;
    !core_supply_ok ##1 !core_supply_ok;
  endsequence
  chk_b_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_bus_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write open during response");
  chk_core_off:
    assert property (s_core_lost |-> ##[0:3] (!iface_enable && !analog_enable))
    else $error("core loss not obeyed");
  chk_start_pulse:
    assert property (conv_start |=> !conv_start) else $error("start too long");
  chk_start_fields:
    assert property (conv_start |-> conv_oversample != 3'h0 && conv_channel != 2'h3)
    else $error("bad request fields");
  chk_start_active:
    assert property (conv_start |-> analog_enable) else $error("start while idle");
  chk_chan_hold:
    assert property (conv_start ##1 !conv_start |-> $stable(conv_channel))
    else $error("channel moved");
endmodule
bind envsq_core envsq_core_props u_props (.clock, .sys_rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .core_supply_ok, .iface_enable, .analog_enable,
  .conv_start, .conv_channel, .conv_oversample);

/* tb_envsq_core.sv */
// testbench for the mode sequencer core with the front end model
// assumes the core, its header, the model and the checker compiled first
`timescale 1ns/1ps
module tb_envsq_core;
  logic clock = 0, sys_rst = 1, slow = 0;
  logic core_supply_ok = 1, interface_supply_ok = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
  logic s_axi_arvalid = 0, s_axi_rready = 1, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, iface_enable, analog_enable;
  logic conv_start, conv_done;
  logic [1:0] s_axi_bresp, s_axi_rresp, conv_channel, rsp;
  logic [2:0] conv_oversample;
  logic [19:0] conv_result, base = 0;
  logic [5:0] order_log;
  int err_total = 0, total_checks = 0, gap = 0, cyc = 0, t0 = 0;
  always #5 clock = ~clock;
  envsq_core #(.HALF_MS_CYCLES(4)) u_dut (.clock, .sys_rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .core_supply_ok, .interface_supply_ok, .iface_enable,
    .analog_enable, .conv_start, .conv_channel, .conv_oversample, .conv_done,
    .conv_result);
  envsq_fe_model u_fe (.clock, .slow, .conv_start, .conv_channel, .base,
    .conv_done, .conv_result, .order_log);
  // ****
  // helpers
  // ****
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (conv_start === 1'b1 && conv_channel === 2'h0) begin
      gap <= cyc - t0;
      t0 <= cyc;
    end
  end
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic step(inout int n);
    @(posedge clock);
    n++;
    if (n > 5000) begin
      err_total++;
      report_and_stop();
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er = 2'h0);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      step(n);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask
  task automatic rd(logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      step(n);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  task automatic rdc(string nm, logic [7:0] a, logic [31:0] e);
    rd(a);
    chk(nm, e, rdv);
  endtask
  task automatic poll(string nm, logic [7:0] a, logic [31:0] m, logic [31:0] v);
    int n;
    n = 0;
    do begin
      rd(a);
      n++;
    end while ((rdv & m) !== v && n < 300);
    chk(nm, v, rdv & m);
  endtask
  task automatic shot(logic [31:0] c, logic [19:0] b);
    base <= b;
    wr(8'h00, c);
    poll("measuring", 8'h10, 32'h1, 32'h0);
  endtask
  task automatic wait_temp(int k);
    int n;
    n = 0;
    repeat (k) begin
      step(n);
      while (!(conv_start === 1'b1 && conv_channel === 2'h0)) step(n);
    end
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    logic [7:0] ra[4] = '{8'h00, 8'h04, 8'h08, 8'h10};
    foreach (ra[i]) rdc("reset", ra[i], 32'h0);
    rd(8'h20);
    chk("unmapped", 32'h2, 32'(rsp));
    wr(8'h20, 32'h1, 2'h2);
  endtask
  task automatic t_oneshot;
    for (int i = 0; i < 2; i++) begin
      slow <= i[0];
      wr(8'h08, 32'h1);
      shot(32'h25 + i, 20'h0fff0 + 20'(i));
      rdc("temp", 8'h14, 32'h0fff0 + i);
      rdc("press", 8'h18, 32'h0fff1 + i);
      rdc("hum", 8'h1c, 32'hfff2 + i);
      chk("order", 32'h6, 32'(order_log));
      rdc("mode", 8'h00, 32'h24);
    end
  endtask
  task automatic t_filter;
    wr(8'h04, 32'h10);
    shot(32'h25, 20'h00100);
    rdc("first", 8'h14, 32'h100);
    shot(32'h25, 20'h00300);
    rdc("temp f", 8'h14, 32'h200);
    rdc("press f", 8'h18, 32'h201);
    rdc("hum", 8'h1c, 32'h302);
    wr(8'h08, 32'h0);
    shot(32'h21, 20'h00500);
    rdc("skip", 8'h14, 32'h80000);
    rdc("press f", 8'h18, 32'h381);
    rdc("hum kept", 8'h1c, 32'h302);
    chk("order", 32'h1, 32'(order_log[1:0]));
    shot(32'h25, 20'h00600);
    rdc("memory", 8'h14, 32'h400);
  endtask
  task automatic t_periodic;
    int g0;
    slow <= 1'b1;
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h25);
    wr(8'h00, 32'h27);
    rdc("pending", 8'h10, 32'h7);
    wr(8'h08, 32'h3);
    wr(8'h00, 32'h24);
    poll("periodic", 8'h10, 32'he, 32'hc);
    rdc("hum drop", 8'h08, 32'h0);
    base <= 20'h00777;
    poll("newest", 8'h14, 32'hfffff, 32'h777);
    wait_temp(2);
    g0 = gap;
    wr(8'h04, 32'h6);
    wait_temp(3);
    chk("standby", 32'(g0 + 76), 32'(gap));
    wr(8'h0c, 32'h5a);
    poll("soft", 8'h10, 32'hf, 32'h0);
    rdc("soft cfg", 8'h04, 32'h0);
  endtask
  task automatic t_supply;
    wr(8'h08, 32'h5);
    interface_supply_ok <= 1'b0;
    repeat (6) @(posedge clock);
    interface_supply_ok <= 1'b1;
    repeat (6) @(posedge clock);
    rdc("io cycle", 8'h08, 32'h5);
    core_supply_ok <= 1'b0;
    repeat (6) @(posedge clock);
    chk("pins off", 32'h0, 32'(iface_enable));
    core_supply_ok <= 1'b1;
    repeat (6) @(posedge clock);
    chk("pins on", 32'h1, 32'(iface_enable));
    rdc("core cycle", 8'h08, 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clock);
    t_reset();
    t_oneshot();
    t_filter();
    t_periodic();
    t_supply();
    report_and_stop();
  end
endmodule
